/* design/uab_regs.svh */
// Register map, field positions, reset values and timing counts of the audio bridge.
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH

`define UAB_CTRL_OFS      8'h00
`define UAB_LOWWM_OFS     8'h04
`define UAB_HIGHWM_OFS    8'h08
`define UAB_LARGE_OFS     8'h0C
`define UAB_NOMPKT_OFS    8'h10
`define UAB_SMALL_OFS     8'h14
`define UAB_STAT_OFS      8'h18
`define UAB_RATE_OFS      8'h1C

`define UAB_IN_EN_BIT     0
`define UAB_OUT_EN_BIT    1
`define UAB_IN_MODE_LSB   2
`define UAB_OUT_MODE_LSB  4
`define UAB_OVR_BIT       18
`define UAB_UND_BIT       19

`define UAB_CODE_SYNC     2'h1
`define UAB_CODE_ADAPT    2'h2

`define UAB_CTRL_RST      6'h23
`define UAB_LOWWM_RST     7'h10
`define UAB_HIGHWM_RST    7'h30
`define UAB_LARGE_RST     10'h0C4
`define UAB_NOMPKT_RST    10'h0C0
`define UAB_SMALL_RST     10'h0BC

`define UAB_FIFO_DEPTH    64
`define UAB_CLK_NS        50
`define UAB_FRAME_NS      1000000
`define UAB_FRAME_CYC     (`UAB_FRAME_NS / `UAB_CLK_NS)
`define UAB_SYNC_FRAMES   256
// Oscillator step for a 12.288 MHz tick from 20 MHz: 12.288 / 20 * 2^32.
`define UAB_NCO_NOM       32'h9D49_5182
`define UAB_RATE_STEP     32'h0001_0000
`define UAB_SYNC_SHIFT    9

`endif

/* design/uab_pkg.sv */
// Types and decode helpers of the serial audio bridge.
`include "uab_regs.svh"
package uab_pkg;
    typedef enum logic [2:0] {
        UAB_ASYNC = 3'h1,
        UAB_SYNC  = 3'h2,
        UAB_ADAPT = 3'h4
    } uab_mode_t;

    typedef enum logic [2:0] {
        UAB_BELOW   = 3'h1,
        UAB_BETWEEN = 3'h2,
        UAB_ABOVE   = 3'h4
    } uab_band_t;

    function automatic uab_mode_t uab_mode_dec(input logic [1:0] code);
        case (code)
            `UAB_CODE_SYNC:  uab_mode_dec = UAB_SYNC;
            `UAB_CODE_ADAPT: uab_mode_dec = UAB_ADAPT;
            default:         uab_mode_dec = UAB_ASYNC;
        endcase
    endfunction

    function automatic uab_band_t uab_band(input logic [15:0] lvl,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
        if (lvl > hi)
            uab_band = UAB_ABOVE;
        else if (lvl < lo)
            uab_band = UAB_BELOW;
        else
            uab_band = UAB_BETWEEN;
    endfunction
endpackage

/* design/uab_stream_if.sv */
// Valid/ready word stream between the bridge blocks.
`timescale 1ns/1ns
interface uab_stream_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* design/uab_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module uab_fifo #(
    parameter int W = 32,
    parameter int D = 64
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Stream sides
    uab_stream_if.snk                  wr,
    uab_stream_if.src                  rd,
    // Occupancy
    output logic [$clog2(D+1)-1:0]     level
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int LW = $clog2(D + 1);

    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wr_idx_ff;
    logic [AW-1:0] rd_idx_ff;
    logic [LW-1:0] cnt_ff;
    logic [LW-1:0] nxt_cnt;
    logic          rdy_ff;
    logic          vld_ff;
    logic          push;
    logic          pop;

    function automatic logic [AW-1:0] idx_inc(input logic [AW-1:0] idx);
        idx_inc = (idx == AW'(D - 1)) ? {AW{1'b0}} : idx + 1'b1;
    endfunction

    assign push     = wr.valid & rdy_ff;
    assign pop      = rd.ready & vld_ff;
    assign nxt_cnt  = cnt_ff + LW'(push) - LW'(pop);
    assign wr.ready = rdy_ff;
    assign rd.valid = vld_ff;
    assign rd.data  = mem_ff[rd_idx_ff];
    assign level    = cnt_ff;

    // Full and empty are registered so both ready and valid come from flops.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff    <= {LW{1'b0}};
            rdy_ff    <= 1'b0;
            vld_ff    <= 1'b0;
            wr_idx_ff <= {AW{1'b0}};
            rd_idx_ff <= {AW{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_cnt != LW'(D);
            vld_ff <= nxt_cnt != {LW{1'b0}};
            if (push)
                wr_idx_ff <= idx_inc(wr_idx_ff);
            if (pop)
                rd_idx_ff <= idx_inc(rd_idx_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (push)
            mem_ff[wr_idx_ff] <= wr.data;
    end
endmodule

/* design/uab_top.sv */
// Serial audio bridge: codec link, stream FIFOs, rate control and AHB-Lite registers.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "uab_regs.svh"
// How it works
// RULE_01: Codec pins: data in/out, clocks, detect.
// RULE_02: Output line carries playback only.
// RULE_03: Async, sync, adaptive selectable per direction.
// RULE_04: Default async capture, adaptive playback, 48k.
// RULE_05: Async capture clock fixed at 48k; code takes the clock mode from playback whenever playback is enabled.
// RULE_06: Codec samples written into input FIFO.
// RULE_07: Input FIFO compared with two watermarks.
// RULE_08: Packet size follows input FIFO band.
// RULE_09: Playback starts at 48k, fills OUT FIFO.
// RULE_10: Host sends constant data per frame.
// RULE_11: Raise sample clock above high watermark.
// RULE_12: Hold between, lower below low watermark.
// RULE_13: Sync clock locked to frame markers.
// RULE_14: Measure frame timing over long window.
// RULE_15: Sample clock derived from measured rate.
// RULE_16: Pins active only when strapped on.
// RULE_17: Equal to watermark counts as between.
module uab_top
    import uab_pkg::*;
#(
    parameter int FIFO_DEPTH   = `UAB_FIFO_DEPTH,
    parameter int SYNC_FRAMES  = `UAB_SYNC_FRAMES,
    parameter int SYNC_WIN_CYC = `UAB_FRAME_CYC * `UAB_SYNC_FRAMES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // USB stream side
    input  wire logic        sof,
    input  wire logic        out_wr_valid,
    output logic             out_wr_ready,
    input  wire logic [31:0] out_wr_data,
    output logic             in_rd_valid,
    input  wire logic        in_rd_ready,
    output logic [31:0]      in_rd_data,
    output logic [9:0]       in_pkt_bytes,
    output logic             in_pkt_strobe,
    // Codec pins
    input  wire logic        audio_pin_strap,
    input  wire logic        audio_serial_in,
    input  wire logic        microphone_plug_detect,
    output logic             audio_serial_out,
    output logic             audio_bit_clock,
    output logic             audio_word_clock,
    output logic             audio_master_clock,
    output logic             audio_pins_oe
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int CW = $clog2(SYNC_WIN_CYC * 2);
    localparam int FW = $clog2(SYNC_FRAMES);

    logic          in_en_ff, out_en_ff, strap_ff, strap_done_ff, mic_ff, ovr_ff, und_ff;
    logic [1:0]    in_code_ff, out_code_ff;
    logic [LW-1:0] low_wm_ff, high_wm_ff, in_lvl, out_lvl;
    logic [9:0]    large_ff, nom_ff, small_ff, in_pkt_bytes_ff;
    logic          in_pkt_strobe_ff, wr_pend_ff, pins_oe_ff;
    logic [7:0]    wr_addr_ff;
    logic [31:0]   hrdata_ff, rd_word, acc_ff, inc_ff, tx_ff, rx_ff, cap_word_ff;
    logic [32:0]   nco_sum;
    logic [1:0]    div_ff;
    logic [4:0]    bit_cnt_ff, nxt_bit_cnt, lead_cnt;
    logic          mclk_ff, bclk_ff, wclk_ff, sdo_ff, push_ff;
    logic          run, tick, bclk_tog, fall, rise, load, wr_sel, clr_stat;
    uab_mode_t     clk_mode, in_mode;
    uab_band_t     in_band, out_band;
    logic          started_ff, win_close;
    logic [FW-1:0] nfr_ff;
    logic [CW-1:0] cyc_ff;
    logic signed [CW:0] sync_err;
    logic [31:0]   sync_inc;

    uab_stream_if #(.W(32)) in_w (), in_m (), in_q (), out_w (), out_r ();

    // AHB-Lite slave: zero wait, always OKAY, read data registered in the address phase.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign wr_sel    = hsel & hready & htrans[1];
    assign clr_stat  = wr_pend_ff & (wr_addr_ff == `UAB_STAT_OFS);

    always_comb begin
        case (haddr[7:0])
            `UAB_CTRL_OFS:   rd_word = {26'h0, out_code_ff, in_code_ff, out_en_ff, in_en_ff};
            `UAB_LOWWM_OFS:  rd_word = 32'(low_wm_ff);
            `UAB_HIGHWM_OFS: rd_word = 32'(high_wm_ff);
            `UAB_LARGE_OFS:  rd_word = 32'(large_ff);
            `UAB_NOMPKT_OFS: rd_word = 32'(nom_ff);
            `UAB_SMALL_OFS:  rd_word = 32'(small_ff);
            `UAB_STAT_OFS:   rd_word = {2'h0, in_pkt_bytes_ff, und_ff, ovr_ff, strap_ff, mic_ff,
                                        1'b0, 7'(out_lvl), 1'b0, 7'(in_lvl)};
            `UAB_RATE_OFS:   rd_word = inc_ff;
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend_ff <= wr_sel & hwrite;
            wr_addr_ff <= haddr[7:0];
            if (wr_sel & ~hwrite)
                hrdata_ff <= rd_word;
        end
    end

    // RULE_03: Per-direction mode fields.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {out_code_ff, in_code_ff, out_en_ff, in_en_ff} <= `UAB_CTRL_RST;
            low_wm_ff  <= LW'(`UAB_LOWWM_RST);
            high_wm_ff <= LW'(`UAB_HIGHWM_RST);
            large_ff   <= `UAB_LARGE_RST;
            nom_ff     <= `UAB_NOMPKT_RST;
            small_ff   <= `UAB_SMALL_RST;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                `UAB_CTRL_OFS: begin
                    in_en_ff    <= hwdata[`UAB_IN_EN_BIT];
                    out_en_ff   <= hwdata[`UAB_OUT_EN_BIT];
                    in_code_ff  <= hwdata[`UAB_IN_MODE_LSB +: 2];
                    out_code_ff <= hwdata[`UAB_OUT_MODE_LSB +: 2];
                end
                `UAB_LOWWM_OFS:  low_wm_ff  <= hwdata[LW-1:0];
                `UAB_HIGHWM_OFS: high_wm_ff <= hwdata[LW-1:0];
                `UAB_LARGE_OFS:  large_ff   <= hwdata[9:0];
                `UAB_NOMPKT_OFS: nom_ff     <= hwdata[9:0];
                `UAB_SMALL_OFS:  small_ff   <= hwdata[9:0];
                default: ;
            endcase
        end
    end

    // RULE_16: Strap caught once after reset gates the pins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_ff      <= 1'b0;
            strap_done_ff <= 1'b0;
            pins_oe_ff    <= 1'b0;
            mic_ff        <= 1'b0;
        end else begin
            if (!strap_done_ff)
                strap_ff <= audio_pin_strap;
            strap_done_ff <= 1'b1;
            pins_oe_ff    <= strap_ff;
            mic_ff        <= strap_ff & microphone_plug_detect;
        end
    end

    // Sticky errors; a new event wins over a write-one clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovr_ff <= 1'b0;
            und_ff <= 1'b0;
        end else begin
            ovr_ff <= (push_ff & ~in_w.ready) | (ovr_ff & ~(clr_stat & hwdata[`UAB_OVR_BIT]));
            und_ff <= (load & out_en_ff & ~out_r.valid)
                    | (und_ff & ~(clr_stat & hwdata[`UAB_UND_BIT]));
        end
    end

    // RULE_07: Occupancy bands; RULE_17 equal levels fall between.
    assign in_band  = uab_band(16'(in_lvl), 16'(low_wm_ff), 16'(high_wm_ff));
    assign out_band = uab_band(16'(out_lvl), 16'(low_wm_ff), 16'(high_wm_ff));
    assign in_mode  = uab_mode_dec(in_code_ff);
    assign clk_mode = uab_mode_dec(out_en_ff ? out_code_ff : in_code_ff);
    assign run      = strap_ff & (in_en_ff | out_en_ff);

    // RULE_01: Oscillator makes master clock; bit clock is a quarter of it.
    assign nco_sum  = {1'b0, acc_ff} + {1'b0, inc_ff};
    assign tick     = nco_sum[32];
    assign bclk_tog = tick & (div_ff == 2'h3);
    assign fall     = bclk_tog & bclk_ff;
    assign rise     = bclk_tog & ~bclk_ff;
    assign load     = fall & (bit_cnt_ff == 5'h1F);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff  <= 32'h0000_0000;
            div_ff  <= 2'h0;
            mclk_ff <= 1'b0;
            bclk_ff <= 1'b0;
        end else if (!run) begin
            acc_ff  <= 32'h0000_0000;
            div_ff  <= 2'h0;
            mclk_ff <= 1'b0;
            bclk_ff <= 1'b0;
        end else begin
            acc_ff <= nco_sum[31:0];
            if (tick) begin
                mclk_ff <= ~mclk_ff;
                div_ff  <= div_ff + 2'h1;
            end
            if (bclk_tog)
                bclk_ff <= ~bclk_ff;
        end
    end

    // RULE_02: Output line only shifts playback words; word clock leads data by one bit.
    assign nxt_bit_cnt = bit_cnt_ff + 5'h01;
    assign lead_cnt    = bit_cnt_ff + 5'h02;
    assign out_r.ready = load & out_en_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt_ff <= 5'h1E;
            wclk_ff    <= 1'b0;
            sdo_ff     <= 1'b0;
            tx_ff      <= 32'h0000_0000;
        end else if (!run) begin
            bit_cnt_ff <= 5'h1E;
            wclk_ff    <= 1'b0;
            sdo_ff     <= 1'b0;
            tx_ff      <= 32'h0000_0000;
        end else if (fall) begin
            bit_cnt_ff <= nxt_bit_cnt;
            wclk_ff    <= lead_cnt[4];
            if (load) begin
                tx_ff  <= (out_en_ff & out_r.valid) ? {out_r.data[30:0], 1'b0} : 32'h0000_0000;
                sdo_ff <= out_en_ff & out_r.valid & out_r.data[31];
            end else begin
                tx_ff  <= {tx_ff[30:0], 1'b0};
                sdo_ff <= tx_ff[31];
            end
        end
    end

    // RULE_06: Each complete stereo word is pushed into the input FIFO while capture is enabled.
    assign in_w.valid = push_ff;
    assign in_w.data  = cap_word_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_ff       <= 32'h0000_0000;
            cap_word_ff <= 32'h0000_0000;
            push_ff     <= 1'b0;
        end else begin
            push_ff <= run & rise & in_en_ff & (bit_cnt_ff == 5'h1F);
            if (run & rise) begin
                rx_ff <= {rx_ff[30:0], audio_serial_in};
                if (bit_cnt_ff == 5'h1F)
                    cap_word_ff <= {rx_ff[30:0], audio_serial_in};
            end
        end
    end

    // RULE_08: Packet size picked each frame from the input band in async capture mode, nominal otherwise.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_pkt_bytes_ff  <= `UAB_NOMPKT_RST;
            in_pkt_strobe_ff <= 1'b0;
        end else begin
            in_pkt_strobe_ff <= sof & in_en_ff;
            if (sof & in_en_ff) begin
                if (in_mode != UAB_ASYNC)
                    in_pkt_bytes_ff <= nom_ff;
                else begin
                    unique case (in_band)
                        UAB_ABOVE:   in_pkt_bytes_ff <= large_ff;
                        UAB_BETWEEN: in_pkt_bytes_ff <= nom_ff;
                        UAB_BELOW:   in_pkt_bytes_ff <= small_ff;
                        default:     in_pkt_bytes_ff <= nom_ff;
                    endcase
                end
            end
        end
    end

    // RULE_14: Frame markers counted over a long window.
    assign win_close = sof & started_ff & (nfr_ff == FW'(SYNC_FRAMES - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            started_ff <= 1'b0;
            nfr_ff     <= {FW{1'b0}};
            cyc_ff     <= {CW{1'b0}};
        end else if (!run || clk_mode != UAB_SYNC) begin
            started_ff <= 1'b0;
            nfr_ff     <= {FW{1'b0}};
            cyc_ff     <= {CW{1'b0}};
        end else if (sof && (!started_ff || win_close)) begin
            started_ff <= 1'b1;
            nfr_ff     <= {FW{1'b0}};
            cyc_ff     <= CW'(1);
        end else begin
            cyc_ff <= cyc_ff + CW'(started_ff);
            if (sof)
                nfr_ff <= nfr_ff + FW'(1);
        end
    end

    // RULE_15: Step is nominal plus scaled window error.
    assign sync_err = $signed({1'b0, CW'(SYNC_WIN_CYC)}) - $signed({1'b0, cyc_ff});
    assign sync_inc = `UAB_NCO_NOM + (32'(sync_err) <<< `UAB_SYNC_SHIFT);

    // RULE_09: Sample clock steering per mode.
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            inc_ff <= `UAB_NCO_NOM;
        else if (!run)
            inc_ff <= `UAB_NCO_NOM;
        else begin
            unique case (clk_mode)
                // RULE_05: Fixed rate.
                UAB_ASYNC: inc_ff <= `UAB_NCO_NOM;
                // RULE_11: Adaptive raise, RULE_12 hold or lower.
                UAB_ADAPT: begin
                    if (sof & out_en_ff) begin
                        unique case (out_band)
                            UAB_ABOVE: inc_ff <= inc_ff + `UAB_RATE_STEP;
                            UAB_BELOW: inc_ff <= inc_ff - `UAB_RATE_STEP;
                            default:   inc_ff <= inc_ff;
                        endcase
                    end
                end
                // RULE_13: Locked to frame window.
                UAB_SYNC: begin
                    if (win_close)
                        inc_ff <= sync_inc;
                end
                default: inc_ff <= `UAB_NCO_NOM;
            endcase
        end
    end

    // RULE_04: Playback and capture FIFOs plus two-entry input buffer.
    assign out_w.valid  = out_wr_valid;
    assign out_w.data   = out_wr_data;
    assign out_wr_ready = out_w.ready;
    assign in_q.ready   = in_rd_ready;
    assign in_rd_valid  = in_q.valid;
    assign in_rd_data   = in_q.data;
    uab_fifo #(.W(32), .D(FIFO_DEPTH)) u_in_fifo (
        .clk(clk), .rst(rst), .wr(in_w), .rd(in_m), .level(in_lvl));
    uab_fifo #(.W(32), .D(2)) u_in_buf (
        .clk(clk), .rst(rst), .wr(in_m), .rd(in_q), .level());
    uab_fifo #(.W(32), .D(FIFO_DEPTH)) u_out_fifo (
        .clk(clk), .rst(rst), .wr(out_w), .rd(out_r), .level(out_lvl));

    assign in_pkt_bytes       = in_pkt_bytes_ff;
    assign in_pkt_strobe      = in_pkt_strobe_ff;
    assign audio_serial_out   = sdo_ff;
    assign audio_bit_clock    = bclk_ff;
    assign audio_word_clock   = wclk_ff;
    assign audio_master_clock = mclk_ff;
    assign audio_pins_oe      = pins_oe_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pkt_large: assert property ( // RULE_08
        sof && in_en_ff && in_mode == UAB_ASYNC && in_lvl > high_wm_ff
        |=> in_pkt_strobe && in_pkt_bytes == $past(large_ff)) else $error("large size missed");
    a_pkt_small: assert property ( // RULE_08
        sof && in_en_ff && in_mode == UAB_ASYNC && in_lvl < low_wm_ff
        |=> in_pkt_bytes == $past(small_ff)) else $error("small size missed");
    a_wm_equal: assert property ( // RULE_17
        sof && in_en_ff && in_mode == UAB_ASYNC && low_wm_ff <= high_wm_ff
        && (in_lvl == high_wm_ff || in_lvl == low_wm_ff)
        |=> in_pkt_bytes == $past(nom_ff)) else $error("watermark edge not nominal");
    a_rate_up: assert property ( // RULE_11
        run && clk_mode == UAB_ADAPT && sof && out_en_ff && out_lvl > high_wm_ff
        |=> inc_ff == $past(inc_ff) + `UAB_RATE_STEP) else $error("rate not raised");
    a_rate_down: assert property ( // RULE_12
        run && clk_mode == UAB_ADAPT && sof && out_en_ff && out_lvl < low_wm_ff
        |=> inc_ff == $past(inc_ff) - `UAB_RATE_STEP) else $error("rate not lowered");
    a_rate_fixed: assert property ( // RULE_05
        clk_mode == UAB_ASYNC [*2] |-> inc_ff == `UAB_NCO_NOM) else $error("async rate moved");
    a_rate_start: assert property ( // RULE_09
        $rose(run) |-> inc_ff == `UAB_NCO_NOM) else $error("start rate not nominal");
    a_sync_load: assert property ( // RULE_15
        run && clk_mode == UAB_SYNC && win_close |=> inc_ff == $past(sync_inc) && cyc_ff == 1)
        else $error("sync rate not loaded");
    a_pins_off: assert property ( // RULE_16
        !strap_ff |=> !audio_pins_oe && !audio_bit_clock && !audio_master_clock)
        else $error("pins driven without strap");
    a_sdo_quiet: assert property ( // RULE_02
        load && !out_en_ff |=> !audio_serial_out [*2]) else $error("output carries data");
    a_cap_push: assert property ( // RULE_06
        run && rise && in_en_ff && bit_cnt_ff == 5'h1F |=> in_w.valid) else $error("no push");
    a_bclk_half: assert property ( // RULE_04
        run && $changed(bclk_ff) |=> $stable(bclk_ff) [*5]) else $error("bit clock too fast");

    c_pkt_large: cover property (sof && in_en_ff && in_band == UAB_ABOVE);
    c_sync_win: cover property (run && clk_mode == UAB_SYNC && win_close);
    c_overrun: cover property (push_ff && !in_w.ready);
    c_underrun: cover property (load && out_en_ff && !out_r.valid);
endmodule

/* testbench/uab_codec_model.sv */
// Behavioural codec that feeds capture bits to the bridge.
`timescale 1ns/1ns
module uab_codec_model (
    // Codec link
    input  wire logic        bclk,
    input  wire logic        oe,
    input  wire logic        sdo,
    input  wire logic        wclk,
    output logic             sdata,
    // Last playback word rebuilt from the output line
    output logic [31:0]      rx_word
);
    logic [15:0] pat_ff = 16'hA5C3;
    logic [31:0] sh_ff = 32'h0000_0000;
    logic        wclk_ff = 1'b0;
    always @(posedge bclk) begin
        sh_ff   <= {sh_ff[30:0], sdo};
        wclk_ff <= wclk;
        if (!wclk && wclk_ff)
            rx_word <= {sh_ff[30:0], sdo};
    end
    always @(negedge bclk) pat_ff <= {pat_ff[14:0], pat_ff[15]};
    assign sdata = oe ? pat_ff[15] : ~pat_ff[15];
endmodule

/* testbench/testbench.sv */
// Self-checking bench of the serial audio bridge.
`timescale 1ns/1ns
`include "uab_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import uab_pkg::*;
    logic        clk, rst, hsel, hwrite, sof, owv, irr, strap, mic, sdi, hrdy, hresp;
    logic        owr, irv, strb, sdo, bck, wck, mck, oe;
    logic [31:0] haddr, hwdata, hrdata, owd, ird, rd, rxw;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [9:0]  pkb;
    int          n_fail, samples_checked;
    uab_top #(.SYNC_FRAMES(4), .SYNC_WIN_CYC(800)) i_dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .sof(sof),
        .out_wr_valid(owv), .out_wr_ready(owr), .out_wr_data(owd), .in_rd_valid(irv),
        .in_rd_ready(irr), .in_rd_data(ird), .in_pkt_bytes(pkb), .in_pkt_strobe(strb),
        .audio_pin_strap(strap), .audio_serial_in(sdi), .microphone_plug_detect(mic),
        .audio_serial_out(sdo), .audio_bit_clock(bck), .audio_word_clock(wck),
        .audio_master_clock(mck), .audio_pins_oe(oe));
    uab_codec_model i_codec (.bclk(bck), .oe(oe), .sdo(sdo), .wclk(wck), .sdata(sdi),
        .rx_word(rxw));
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hrdy !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic frame(input logic [9:0] eb, input logic [31:0] er);
        sof <= 1'b1;
        @(posedge clk);
        sof <= 1'b0;
        #1;
        `CHK("strobe", 1'b1, strb)
        `CHK("pkt", eb, pkb)
        @(posedge clk);
        ahb(0, `UAB_RATE_OFS, 0);
        `CHK("rate", er, rd)
        $display("frame done");
    endtask
    task automatic t_regs();
        logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
        logic [31:0] rv [7] = '{32'h23, 32'h10, 32'h30, 32'hC4, 32'hC0, 32'hBC, 32'h0};
        for (int i = 0; i < 7; i++) begin
            ahb(0, ofs[i], 0);
            `CHK("reg", rv[i], rd)
        end
        ahb(0, `UAB_STAT_OFS, 0);
        `CHK("mic_strap", 2'h3, rd[17:16])
        `CHK("oe", 1'b1, oe)
        `CHK("hresp", 1'b0, hresp)
        $display("regs done");
    endtask
    task automatic t_flow();
        int          k;
        logic [31:0] w;
        frame(10'h0BC, `UAB_NCO_NOM - `UAB_RATE_STEP);
        ahb(1, `UAB_LOWWM_OFS, 32'h0);
        frame(10'h0C0, `UAB_NCO_NOM - `UAB_RATE_STEP);
        ahb(1, `UAB_HIGHWM_OFS, 32'h0);
        owv <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (owr === 1'b1 && k < 200);
        `CHK("out_full", 1'b0, owr)
        if (k >= 200)
            wrap_up();
        @(posedge clk);
        owv <= 1'b0;
        ahb(0, `UAB_STAT_OFS, 0);
        `CHK("flags", 2'h2, rd[19:18])
        ahb(1, `UAB_STAT_OFS, 32'h0008_0000);
        ahb(0, `UAB_STAT_OFS, 0);
        `CHK("flags_clr", 2'h0, rd[19:18])
        repeat (3000) @(posedge clk);
        `CHK("codec_word", 32'h0000_1234, rxw)
        frame(10'h0C4, `UAB_NCO_NOM);
        irr <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
            if (irv === 1'b1)
                w = ird;
        end while (irv === 1'b1 && k < 200);
        `CHK("in_drained", 1'b0, irv)
        `CHK("in_ones", 16, $countones(w))
        `CHK("in_halves", w[31:16], w[15:0])
        if (k >= 200)
            wrap_up();
        $display("flow done");
    endtask
    task automatic t_sync();
        irr <= 1'b0;
        ahb(1, `UAB_CTRL_OFS, 32'h0000_0017);
        repeat (5) begin
            sof <= 1'b1;
            @(posedge clk);
            sof <= 1'b0;
            repeat (200) @(posedge clk);
        end
        `CHK("sync_pkt", `UAB_NOMPKT_RST, pkb)
        ahb(0, `UAB_RATE_OFS, 0);
        `CHK("sync_rate", `UAB_NCO_NOM - 32'h0000_0800, rd)
        $display("sync done");
    endtask
    task automatic t_nostrap();
        strap <= 1'b0;
        rst   <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        ahb(0, `UAB_STAT_OFS, 0);
        `CHK("mic_strap_off", 2'h0, rd[17:16])
        #1;
        `CHK("oe_off", 1'b0, oe)
        `CHK("clocks_off", 2'h0, {bck, mck})
        $display("nostrap done");
    endtask
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst, strap, mic, hsel, hsize} = 7'h7A;
        {hwrite, sof, owv, irr, htrans} = 6'h0;
        {haddr, hwdata, owd} = {32'h0, 32'h0, 32'h0000_1234};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_flow();
        t_sync();
        t_nostrap();
        wrap_up();
    end
endmodule
